//--- hw/acfg_patgen.sv
// Channel A test pattern generator, ahead of the output bit mapper.
// Assumes one converter sample per clock at native resolution, MSB aligned.
module acfg_patgen #(
    parameter int SAMPLE_W = 14,
    parameter int PAT_W    = 18
) (
    // Clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_srst,
    // Control
    input  wire logic [2:0]          i_pattern_select_a,
    input  wire logic [PAT_W-1:0]    i_user_pattern_value,
    // Sample path
    input  wire logic [SAMPLE_W-1:0] i_sample,
    input  wire logic                i_sample_valid,
    output logic      [SAMPLE_W-1:0] o_sample,
    output logic                     o_sample_valid
);
    import acfg_pkg::*;

    initial begin
        if (SAMPLE_W > PAT_W || SAMPLE_W < 1) $error("acfg_patgen: bad SAMPLE_W");
    end

    logic [PAT_W-1:0]    ramp_reg;
    logic [PAT_W-1:0]    ramp_next;
    logic [SAMPLE_W-1:0] out_next;
    wire                 is_ramp  = (i_pattern_select_a == ACFG_PAT_RAMP);
    wire                 is_const = (i_pattern_select_a == ACFG_PAT_CONSTANT);

    // Ramp wraps modulo 2^18 by width; restarts from zero outside ramp mode
    assign ramp_next = !is_ramp ? '0 :
                       i_sample_valid ? ramp_reg + i_user_pattern_value : ramp_reg; // R11
    // Patterns taken from the MSB end of the 18-bit field
    assign out_next  = is_ramp  ? ramp_reg[PAT_W-1 -: SAMPLE_W] :                  // R10
                       is_const ? i_user_pattern_value[PAT_W-1 -: SAMPLE_W] :      // R11
                       i_sample;                                                   // R9

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ramp_reg       <= '0;
            o_sample       <= '0;
            o_sample_valid <= 1'b0;
        end else begin
            ramp_reg       <= ramp_next;
            o_sample       <= out_next;
            o_sample_valid <= i_sample_valid;
        end
    end

endmodule // acfg_patgen

//--- hw/acfg_regs.sv
// Configuration and test pattern register group of the sampling converter.
// Assumes byte writes/reads arrive on the sampling clock from the serial register port.
//
// Operation
// R1 - Bit 5 of the input configuration register selects differential (0) or single-ended (1) input A, reset 0.
// R2 - Software sets the delay-loop power-down bit 2 below 40 MSPS; it matters only on the fastest grade.
// R3 - Delay-loop power-down 0 samples a quarter period after the edge, 1 follows the clock duty cycle.
// R4 - Auto-zero enable at bit 0 turns the circuit on at 1, resetting enabled on slow grades, off on the fastest.
// R5 - After choosing the interface, software pulses the fuse-load bit 1 then 0; mapping applies after the pulse.
// R6 - Running the fuse load resets earlier register writes, so interface and fuse load go first; the code resets only analog and pattern registers.
// R7 - The 18-bit user pattern spans three registers: 7:0, 15:8 and 17:16 in the low bits, MSB aligned.
// R8 - In ramp mode software loads the step as 00001, 00100 or 10000 for 18, 16 or 14 bit converters.
// R9 - Pattern select at bits 4-2 gives normal for 000, ramp for 010 and constant for 011.
// R10 - Patterns go in ahead of the bit mapper at native resolution, MSB aligned, in every format.
// R11 - Ramp steps by the programmed value each sample, wrapping modulo 2^18; constant repeats each sample.
module acfg_regs #(
    parameter bit FAST_GRADE = 1'b0,
    parameter int SAMPLE_W   = acfg_pkg::ACFG_SAMPLE_W
) (
    // Clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_srst,
    // Register port
    input  wire acfg_pkg::acfg_req_t       i_req,
    output logic      [7:0]                o_rdata,
    output logic                           o_rvalid,
    // Analog controls and mapping apply
    output acfg_pkg::acfg_ctl_t            o_ctl,
    output logic                           o_sample_at_half_period,
    output logic      [7:0]                o_mapping_if_sel,
    output logic                           o_mapping_load_pulse,
    // Channel A samples
    input  wire logic [SAMPLE_W-1:0]       i_sample,
    input  wire logic                      i_sample_valid,
    output logic      [SAMPLE_W-1:0]       o_sample,
    output logic                           o_sample_valid
);
    import acfg_pkg::*;

    initial begin
        if (SAMPLE_W > ACFG_PAT_W) $error("acfg_regs: SAMPLE_W above pattern width");
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] out_if_reg;
    logic [7:0] analog_cfg_reg;
    logic [7:0] fuse_ctl_reg;
    logic [7:0] pat_low_reg;
    logic [7:0] pat_mid_reg;
    logic [7:0] pat_sel_high_reg;
    logic [7:0] map_if_reg;
    logic       fuse_pulse_reg;
    logic [7:0] rdata_next;

    localparam logic [7:0] ANALOG_RST =
        FAST_GRADE ? ACFG_RST_BYTE : (ACFG_RST_BYTE | 8'(ACFG_RST_AZ_SLOW)); // R4

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire wr_out_if  = i_req.wr && (i_req.addr == ACFG_OFS_OUT_IF);
    wire wr_analog  = i_req.wr && (i_req.addr == ACFG_OFS_ANALOG_CFG);
    wire wr_fuse    = i_req.wr && (i_req.addr == ACFG_OFS_FUSE_LOAD);
    wire wr_pat_lo  = i_req.wr && (i_req.addr == ACFG_OFS_PAT_LOW);
    wire wr_pat_mid = i_req.wr && (i_req.addr == ACFG_OFS_PAT_MID);
    wire wr_pat_hi  = i_req.wr && (i_req.addr == ACFG_OFS_PAT_SEL_HIGH);

    // Falling edge of the stored load bit completes the 1-then-0 pulse
    wire fuse_fire  = wr_fuse && fuse_ctl_reg[ACFG_BIT_FUSE_LOAD]
                      && !i_req.wdata[ACFG_BIT_FUSE_LOAD];                      // R5

    wire [ACFG_PAT_W-1:0] user_pattern_value =
        {pat_sel_high_reg[ACFG_POS_PAT_HIGH +: 2], pat_mid_reg, pat_low_reg};   // R7
    wire [2:0] pattern_select_a = pat_sel_high_reg[ACFG_POS_PAT_SEL +: 3];      // R9

    always_comb begin
        unique case (i_req.addr)
            ACFG_OFS_OUT_IF:       rdata_next = out_if_reg;
            ACFG_OFS_ANALOG_CFG:   rdata_next = analog_cfg_reg;
            ACFG_OFS_FUSE_LOAD:    rdata_next = fuse_ctl_reg;
            ACFG_OFS_PAT_LOW:      rdata_next = pat_low_reg;
            ACFG_OFS_PAT_MID:      rdata_next = pat_mid_reg;
            ACFG_OFS_PAT_SEL_HIGH: rdata_next = pat_sel_high_reg;
            default:               rdata_next = ACFG_RST_BYTE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers; the fuse load resets only the analog and pattern registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            out_if_reg       <= ACFG_RST_BYTE;
            fuse_ctl_reg     <= ACFG_RST_BYTE;
            map_if_reg       <= ACFG_RST_BYTE;
            fuse_pulse_reg   <= 1'b0;
        end else begin
            if (wr_out_if)
                out_if_reg   <= i_req.wdata;
            if (wr_fuse)
                fuse_ctl_reg <= i_req.wdata & 8'h01;
            if (fuse_fire)
                map_if_reg   <= out_if_reg;                                     // R5
            fuse_pulse_reg   <= fuse_fire;
        end
    end

    // Interface register survives the load so the mapping can use it
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || fuse_fire) begin                                          // R6
            analog_cfg_reg   <= ANALOG_RST;
            pat_low_reg      <= ACFG_RST_BYTE;
            pat_mid_reg      <= ACFG_RST_BYTE;
            pat_sel_high_reg <= ACFG_RST_BYTE;
        end else begin
            if (wr_analog)
                analog_cfg_reg   <= i_req.wdata & 8'h25;
            if (wr_pat_lo)
                pat_low_reg      <= i_req.wdata;
            if (wr_pat_mid)
                pat_mid_reg      <= i_req.wdata;
            if (wr_pat_hi)
                pat_sel_high_reg <= i_req.wdata & 8'h1F;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_rdata                 <= ACFG_RST_BYTE;
            o_rvalid                <= 1'b0;
            o_ctl                   <= '0;
            o_sample_at_half_period <= 1'b0;
            o_mapping_if_sel        <= ACFG_RST_BYTE;
            o_mapping_load_pulse    <= 1'b0;
        end else begin
            o_rdata                 <= i_req.rd ? rdata_next : ACFG_RST_BYTE;
            o_rvalid                <= i_req.rd;
            o_ctl.single_ended_input_a          <= analog_cfg_reg[ACFG_BIT_SINGLE_ENDED]; // R1
            o_ctl.sampling_delay_loop_powerdown <= analog_cfg_reg[ACFG_BIT_SAMPLING_DELAY_LOOP_POWERDOWN];      // R3
            o_ctl.autozero_enable               <= analog_cfg_reg[ACFG_BIT_AUTOZERO];     // R4
            // Only the fast grade has the delay loop; others always follow duty cycle
            o_sample_at_half_period <= !FAST_GRADE
                                       || analog_cfg_reg[ACFG_BIT_SAMPLING_DELAY_LOOP_POWERDOWN];    // R3
            o_mapping_if_sel        <= map_if_reg;                              // R5
            o_mapping_load_pulse    <= fuse_pulse_reg;                          // R5
        end
    end

    // ------------------------------------------------------------------
    // Pattern insertion before the bit mapper
    // ------------------------------------------------------------------
    acfg_patgen #(
        .SAMPLE_W (SAMPLE_W),
        .PAT_W    (ACFG_PAT_W)
    ) u_patgen (
        .i_ref_clk            (i_ref_clk),
        .i_srst               (i_srst),
        .i_pattern_select_a   (pattern_select_a),
        .i_user_pattern_value (user_pattern_value),
        .i_sample             (i_sample),
        .i_sample_valid       (i_sample_valid),
        .o_sample             (o_sample),
        .o_sample_valid       (o_sample_valid)
    );                                                                          // R10

endmodule // acfg_regs

//--- include/acfg_pkg.sv
// Package for the converter configuration and test pattern register group.
// Assumes a byte-wide serial register port decoded upstream into write/read strobes.
package acfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ACFG_OFS_OUT_IF       = 8'h07;
    localparam logic [7:0] ACFG_OFS_ANALOG_CFG   = 8'h11;
    localparam logic [7:0] ACFG_OFS_FUSE_LOAD    = 8'h13;
    localparam logic [7:0] ACFG_OFS_PAT_LOW      = 8'h14;
    localparam logic [7:0] ACFG_OFS_PAT_MID      = 8'h15;
    localparam logic [7:0] ACFG_OFS_PAT_SEL_HIGH = 8'h16;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ACFG_BIT_SINGLE_ENDED = 5;
    localparam int ACFG_BIT_SAMPLING_DELAY_LOOP_POWERDOWN      = 2;
    localparam int ACFG_BIT_AUTOZERO     = 0;
    localparam int ACFG_BIT_FUSE_LOAD    = 0;
    localparam int ACFG_POS_PAT_SEL      = 2;
    localparam int ACFG_POS_PAT_HIGH     = 0;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] ACFG_RST_BYTE     = 8'h00;
    localparam int         ACFG_PAT_W        = 18;
    localparam int         ACFG_SAMPLE_W     = 14;
    localparam logic       ACFG_RST_AZ_FAST  = 1'b0;
    localparam logic       ACFG_RST_AZ_SLOW  = 1'b1;

    // ------------------------------------------------------------------
    // Pattern select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] ACFG_PAT_NORMAL   = 3'h0;
    localparam logic [2:0] ACFG_PAT_RAMP     = 3'h2;
    localparam logic [2:0] ACFG_PAT_CONSTANT = 3'h3;

    // Register write/read request from the serial register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acfg_req_t;

    // Analog control levels
    typedef struct packed {
        logic single_ended_input_a;
        logic sampling_delay_loop_powerdown;
        logic autozero_enable;
    } acfg_ctl_t;

endpackage

//--- test/acfg_regs_properties.sv
// Concurrent checks on the ports of the converter register group.
// Assumes one clock domain with a synchronous active-high reset.
module acfg_regs_properties
    import acfg_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b0,
    parameter int SAMPLE_W   = 14
) (
    // Clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_srst,
    // Watched ports
    input  wire acfg_pkg::acfg_req_t i_req,
    input  wire logic [7:0]          o_rdata,
    input  wire logic                o_rvalid,
    input  wire acfg_pkg::acfg_ctl_t o_ctl,
    input  wire logic [7:0]          o_mapping_if_sel,
    input  wire logic                o_mapping_load_pulse,
    input  wire logic                i_sample_valid,
    input  wire logic                o_sample_valid
);
    // ------------------------------------------------------------
    // Helper state: shadow of the fuse bit and interface byte
    // ------------------------------------------------------------
    logic       fuse_reg;
    logic [7:0] if_reg;
    wire        w11    = i_req.wr && i_req.addr == ACFG_OFS_ANALOG_CFG;
    wire        fire   = i_req.wr && i_req.addr == ACFG_OFS_FUSE_LOAD && !i_req.wdata[0] && fuse_reg;
    wire        mapped = i_req.addr inside {8'h07, 8'h11, 8'h13, 8'h14, 8'h15, 8'h16};
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            fuse_reg <= 1'b0;
            if_reg   <= 8'h00;
        end else begin
            if (i_req.wr && i_req.addr == ACFG_OFS_FUSE_LOAD) fuse_reg <= i_req.wdata[0];
            if (i_req.wr && i_req.addr == ACFG_OFS_OUT_IF) if_reg <= i_req.wdata;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_SE_FOLLOWS_WRITE: assert property (w11 |-> ##2 o_ctl.single_ended_input_a == $past(i_req.wdata[5], 2))
        else $error("input select does not follow write");
    AST_DLL_FOLLOWS_WRITE: assert property (w11 |-> ##2 o_ctl.sampling_delay_loop_powerdown == $past(i_req.wdata[2], 2))
        else $error("delay loop bit does not follow write");
    AST_AZ_FOLLOWS_WRITE: assert property (w11 |-> ##2 o_ctl.autozero_enable == $past(i_req.wdata[0], 2))
        else $error("auto-zero bit does not follow write");
    AST_FUSE_PULSE: assert property (fire |-> ##2 o_mapping_load_pulse ##1 !o_mapping_load_pulse)
        else $error("load pulse missing or too long");
    AST_PULSE_CAUSE: assert property (o_mapping_load_pulse |-> $past(fire, 2))
        else $error("load pulse without completed fuse load");
    AST_MAP_LATCH: assert property (fire |-> ##2 o_mapping_if_sel == $past(if_reg, 2))
        else $error("mapping byte not taken from interface register");
    AST_FUSE_CLEARS: assert property (fire |-> ##2 o_ctl == 3'(!FAST_GRADE))
        else $error("fuse load does not clear controls");
    // Reads may come back to back, so each read owns exactly the next cycle
    AST_READ_ANSWER: assert property (i_req.rd |=> o_rvalid)
        else $error("read answer missing");
    AST_READ_IDLE: assert property (!i_req.rd |=> !o_rvalid && o_rdata == 8'h00)
        else $error("read answer without read");
    AST_UNMAPPED_ZERO: assert property (i_req.rd && !mapped |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_SAMPLE_VALID: assert property (i_sample_valid |=> o_sample_valid)
        else $error("sample valid lost");
    cover property (fire);
    cover property (o_rvalid);
    cover property (w11 ##2 o_ctl.sampling_delay_loop_powerdown);
endmodule // acfg_regs_properties

bind acfg_regs acfg_regs_properties #(.FAST_GRADE(FAST_GRADE), .SAMPLE_W(SAMPLE_W)) u_props (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_ctl(o_ctl), .o_mapping_if_sel(o_mapping_if_sel),
    .o_mapping_load_pulse(o_mapping_load_pulse), .i_sample_valid(i_sample_valid),
    .o_sample_valid(o_sample_valid)
);

//--- test/tb_top.sv
// Self-checking bench for the converter register group.
// Assumes the fast grade build, so delay-loop and auto-zero reset behaviour are visible.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acfg_pkg::*;
    logic        i_ref_clk, i_srst, i_sample_valid, o_rvalid, o_half, o_pulse, o_sample_valid;
    acfg_req_t   i_req;
    acfg_ctl_t   o_ctl;
    logic [7:0]  o_rdata, o_if_sel;
    logic [13:0] i_sample, o_sample, prev;
    int          fail_count, checks_done, pulses;

    acfg_regs #(.FAST_GRADE(1'b1)) u_dut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_ctl(o_ctl), .o_sample_at_half_period(o_half),
        .o_mapping_if_sel(o_if_sel), .o_mapping_load_pulse(o_pulse), .i_sample(i_sample),
        .i_sample_valid(i_sample_valid), .o_sample(o_sample), .o_sample_valid(o_sample_valid)
    );
    // ------------------------------------------------------------
    // Clock, pulse counter and tasks
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Sampled on the falling edge so the registered pulse has settled
    always @(negedge i_ref_clk) if (o_pulse === 1'b1) pulses++;
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) i_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_ref_clk) i_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk) i_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_ref_clk) i_req <= '0;
        #1;
        chk(o_rvalid, 1'b1);
        chk(o_rdata, exp);
    endtask
    task automatic settle();
        repeat (4) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bound well above the longest ramp run
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        i_srst = 1'b1;
        i_req = '0;
        i_sample = 14'h1234;
        i_sample_valid = 1'b1;
        fail_count = 0;
        checks_done = 0;
        pulses = 0;
        repeat (16) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        for (int k = 0; k < 4; k++) rd(k == 0 ? 8'h11 : 8'(8'h13 + k), 8'h00);
        rd(8'h20, 8'h00);
        settle();
        chk(o_sample_valid, 1'b1);
        chk(o_ctl, 3'h0);
        chk(o_half, 1'b0);
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h25);
        settle();
        chk(o_ctl, 3'h7);
        chk(o_half, 1'b1);
        wr(8'h11, 8'h00);
        settle();
        chk(o_half, 1'b0);
        wr(8'h07, 8'hA5);
        wr(8'h13, 8'hFF);
        rd(8'h13, 8'h01);
        wr(8'h11, 8'h21);
        wr(8'h13, 8'h00);
        settle();
        chk(o_if_sel, 8'hA5);
        chk(pulses, 1);
        rd(8'h11, 8'h00);
        rd(8'h07, 8'hA5);
        wr(8'h14, 8'hCD);
        wr(8'h15, 8'hAB);
        wr(8'h16, 8'hFF);
        rd(8'h16, 8'h1F);
        rd(8'h15, 8'hAB);
        // Every select code but ramp; constant shows pattern bits 17:4
        for (int c = 0; c < 8; c++) begin
            wr(8'h16, 8'(c << 2) | 8'h03);
            settle();
            if (c != 2) chk(o_sample, c == 3 ? 14'h3ABC : 14'h1234);
        end
        wr(8'h14, 8'h10);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h08);
        settle();
        prev = o_sample;
        // Long enough to cross the 14-bit wrap of the ramp
        repeat (16400) begin
            @(posedge i_ref_clk);
            #1;
            chk(o_sample, 14'(prev + 14'h1));
            prev = o_sample;
        end
        final_report();
    end
endmodule // tb_top
